// ==== pkg/pst_pkg.sv ====
// constants, field positions and carrier types of the peripheral status and timer register bank
package pst_pkg;

   // register indices on the plain register port
   localparam logic [3:0] PST_IDX_CONV_UPPER  = 4'h0;
   localparam logic [3:0] PST_IDX_CONV_NIBBLE = 4'h1;
   localparam logic [3:0] PST_IDX_CONV_LOW    = 4'h2;
   localparam logic [3:0] PST_IDX_EVT_STATUS  = 4'h3;
   localparam logic [3:0] PST_IDX_TMR_FLAGS   = 4'h4;
   localparam logic [3:0] PST_IDX_MAIN_PRESC  = 4'h5;
   localparam logic [3:0] PST_IDX_PORT5_DIR   = 4'h6;
   localparam logic [3:0] PST_IDX_PORT6_DIR   = 4'h7;
   localparam logic [3:0] PST_IDX_PORT7_DIR   = 4'h8;
   localparam logic [3:0] PST_IDX_TMR_A_CFG   = 4'h9;
   localparam logic [3:0] PST_IDX_TMR_BC_CFG  = 4'ha;
   localparam logic [3:0] PST_IDX_CARRIER_CFG = 4'hb;
   localparam logic [3:0] PST_IDX_SECOND_MASK = 4'hc;
   localparam logic [3:0] PST_IDX_FIRST_MASK  = 4'hd;
   localparam logic [3:0] PST_IDX_CONV_CTRL   = 4'he;

   // writable bit masks, reserved bits stay zero
   localparam logic [7:0] PST_WM_EVT_STATUS  = 8'h0b;
   localparam logic [7:0] PST_WM_MAIN_PRESC  = 8'h0f;
   localparam logic [7:0] PST_WM_PORT5_DIR   = 8'h2f;
   localparam logic [7:0] PST_WM_PORT6_DIR   = 8'h80;
   localparam logic [7:0] PST_WM_PORT7_DIR   = 8'hff;
   localparam logic [7:0] PST_WM_TMR_A_CFG   = 8'h04;
   localparam logic [7:0] PST_WM_TMR_BC_CFG  = 8'hc4;
   localparam logic [7:0] PST_WM_CARRIER_CFG = 8'hff;
   localparam logic [7:0] PST_WM_SECOND_MASK = 8'had;
   localparam logic [7:0] PST_WM_FIRST_MASK  = 8'hfb;
   localparam logic [7:0] PST_WM_TMR_FLAGS   = 8'hfb;

   // reset values
   localparam logic [7:0] PST_RST_ZERO = 8'h00;
   localparam logic [7:0] PST_RST_DIR  = 8'hff;
   localparam logic [7:0] PST_RST_PRE  = 8'h00;

   // field positions
   localparam int PST_B_SUPPLY_OK   = 7;
   localparam int PST_B_LOW_SUPPLY  = 6;
   localparam int PST_B_CONV_DONE   = 5;
   localparam int PST_B_CONV_WAKE   = 3;
   localparam int PST_B_PORT_WAKE   = 1;
   localparam int PST_B_LOW_WAKE    = 0;
   localparam int PST_B_GLOBAL_EN   = 6;
   localparam int PST_B_MAIN_PS_EN  = 3;
   localparam int PST_B_TMR_A_EN    = 2;
   localparam int PST_B_TMR_B_WIDE  = 7;
   localparam int PST_B_TMR_B_EN    = 6;
   localparam int PST_B_TMR_C_EN    = 2;
   localparam int PST_B_C_SCALE_EN  = 7;
   localparam int PST_B_MODULATOR   = 3;
   localparam int PST_B_CARRIER_HF  = 2;
   localparam int PST_B_CONV_RUN    = 4;
   localparam int PST_B_P6_IR_PIN   = 7;

   // hardware events from the timers, pulse-width timers and converter, one-cycle pulses
   typedef struct packed {
      logic low_pulse_underflow;
      logic high_pulse_underflow;
      logic timer_c_overflow;
      logic timer_b_overflow;
      logic timer_a_overflow;
      logic main_timer_overflow;
      logic conv_done;
   } pst_evt_type;

   // timer steering towards the counters
   typedef struct packed {
      logic timer_a_en;
      logic timer_b_en;
      logic timer_b_wide_en;
      logic timer_c_en;
      logic timer_c_up_mode;
      logic main_tick;
      logic timer_c_tick;
   } pst_tmr_type;

   // interrupt controller strobes from the core
   typedef struct packed {
      logic irq_on_instr;
      logic irq_off_instr;
      logic irq_return_instr;
      logic irq_taken;
   } pst_irq_cmd_type;

endpackage

// ==== src/pst_regs.sv ====
// peripheral status, wake-up and timer configuration register bank
// Behaviour
// - conversion end loads result, drops running bit, sets done flag together
// - result read as bits 11..4, zero-padded 11..8, and 7..0
// - low-supply and conversion-done flags cleared by write, never set
// - status and wake register reads ANDed with second interrupt mask
// - bit 7 read-only, zero while supply is below the selected level
// - conversion-done and low-supply flags stay set until software clears
// - wake enables for conversion, port 5 change, low supply
// - timer and port-change flags clearable by write, never set by write
// - timer flag register reads ANDed with first interrupt mask
// - overflow of timers c, b, a and main sets their sticky flags
// - any port 5 input change sets sticky port-change flag
// - pulse-width timer underflows set bits 7 and 6, software clears
// - global enable read-only: set by enable/return, cleared by disable/take
// - main prescaler: off gives 1:1, else 1:2 doubling to 1:256
// - main timer overflow period is ratio times remaining counts
// - direction bit 0 drives the pin, 1 leaves it high impedance
// - timer a configuration bit 2 enables timer a, only bit kept
// - timer b wide bit selects 16-bit, default 8-bit
// - bit 6 enables timer b, bit 2 enables timer c
// - timer c scale: off gives 1:1, else 1:2 doubling to 1:256
// - modulator plus high-frequency mode takes scale from carrier low segments
// - modulator off holds infrared pin high; on, port 6.7 is infrared out
// - software sets conversion-running; only completion clears it
// - interrupt request needs individual mask bit and global enable
`timescale 1ns/100ps
`default_nettype none

module pst_regs
   import pst_pkg::*;
(
   input  wire logic            i_clk,            // 20 mhz system clock
   input  wire logic            i_sys_rst,        // async reset, active high
   input  wire logic [3:0]      i_addr,           // register index
   input  wire logic [7:0]      i_wdata,          // write data
   input  wire logic            i_wr,             // write strobe
   input  wire logic            i_rd,             // read strobe
   output logic      [7:0]      o_rdata,          // read data, cycle after strobe
   input  wire pst_evt_type     i_evt,            // peripheral event pulses
   input  wire logic [11:0]     i_conv_result,    // converter result, valid with done
   input  wire pst_irq_cmd_type i_irq_cmd,        // core interrupt strobes
   input  wire logic            i_supply_low,     // detector level, asynchronous
   input  wire logic [7:0]      i_port5_pins,     // port 5 pin levels, asynchronous
   input  wire logic            i_carrier_low_tick, // tick from carrier low segments
   input  wire logic            i_modulated_wave, // modulator datapath level
   output pst_tmr_type          o_tmr,            // timer steering
   output logic                 o_conv_start,     // one-cycle start pulse
   output logic                 o_irq_req,        // masked, globally enabled request
   output logic                 o_wake,           // wake-up request
   output logic [7:0]           o_port5_oe,       // port 5 output enables
   output logic [7:0]           o_port6_oe,       // port 6 output enables
   output logic [7:0]           o_port7_oe,       // port 7 output enables
   output logic                 o_infrared_out_pin, // infrared output level
   output logic                 o_infrared_pin_sel  // port 6.7 used as infrared out
);

   // terminal count of a power-of-two divider, zero means every cycle
   function automatic logic [7:0] ratio_term(input logic en, input logic [2:0] sel);
      logic [8:0] full;
      full = 9'h002 << sel;
      ratio_term = en ? 8'(full - 9'h001) : 8'h00;
   endfunction

   // masked write keeping reserved bits at zero
   function automatic logic [7:0] wr_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] wm);
      wr_merge = (old_v & ~wm) | (new_v & wm);
   endfunction

   logic [11:0] conv_result_q;
   logic        conv_running_q;
   logic        conv_done_flag_q;
   logic        low_supply_flag_q;
   logic [7:0]  wake_cfg_q;
   logic [7:0]  tmr_flags_q;
   logic [7:0]  main_presc_q;
   logic        global_en_q;
   logic [7:0]  port5_dir_q;
   logic [7:0]  port6_dir_q;
   logic [7:0]  port7_dir_q;
   logic [7:0]  tmr_a_cfg_q;
   logic [7:0]  tmr_bc_cfg_q;
   logic [7:0]  carrier_cfg_q;
   logic [7:0]  second_mask_q;
   logic [7:0]  first_mask_q;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;
   logic [7:0]  main_cnt_q;
   logic [7:0]  c_cnt_q;
   logic [2:0]  supply_sync_q;
   logic        supply_low_q;
   logic [7:0]  p5_s1_q;
   logic [7:0]  p5_s2_q;
   logic [7:0]  p5_s3_q;
   logic [7:0]  p5_stable_q;
   logic [3:0]  p5_init_q;
   logic [7:0]  p5_next;
   logic        port_changed;
   logic        supply_fell;
   logic [7:0]  evt_status_raw;
   logic [7:0]  tmr_set;
   logic [7:0]  main_term;
   logic [7:0]  c_term;
   logic        c_up_mode;
   logic        wr_evt;
   logic        wr_tmr;
   logic        main_tick;
   logic        c_tick;

   assign wr_evt = i_wr && (i_addr == PST_IDX_EVT_STATUS);
   assign wr_tmr = i_wr && (i_addr == PST_IDX_TMR_FLAGS);

   // three-stage synchroniser for the supply detector; the first stage feeds only the second
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         supply_sync_q <= 3'h0;
         supply_low_q  <= 1'b0;
      end else begin
         supply_sync_q <= {supply_sync_q[1:0], i_supply_low};
         if (supply_sync_q[1] == supply_sync_q[2]) begin
            supply_low_q <= supply_sync_q[2];
         end
      end
   end

   assign supply_fell = (supply_sync_q[1] == supply_sync_q[2]) && supply_sync_q[2]
                        && !supply_low_q;

   // port 5 synchroniser; a bit changes once its second and third stages agree
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         p5_s1_q     <= 8'h00;
         p5_s2_q     <= 8'h00;
         p5_s3_q     <= 8'h00;
         p5_stable_q <= 8'h00;
         p5_init_q   <= 4'h0;
      end else begin
         p5_s1_q     <= i_port5_pins;
         p5_s2_q     <= p5_s1_q;
         p5_s3_q     <= p5_s2_q;
         p5_stable_q <= p5_next;
         p5_init_q   <= {p5_init_q[2:0], 1'b1};
      end
   end

   // the stable copy takes agreed bits; four cycles after reset only prime it,
   // since the pins may sit at any level and must not look like a change
   assign p5_next      = (p5_stable_q & ~(p5_s2_q ~^ p5_s3_q)) | (p5_s3_q & (p5_s2_q ~^ p5_s3_q));
   assign port_changed = p5_init_q[3] && (p5_next != p5_stable_q);

   // converter result is captured only on completion
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         conv_result_q <= 12'h000;
      end else if (i_evt.conv_done) begin
         conv_result_q <= i_conv_result;
      end
   end

   // running bit: software may only set it, completion drops it
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         conv_running_q <= 1'b0;
      end else if (i_wr && (i_addr == PST_IDX_CONV_CTRL) && i_wdata[PST_B_CONV_RUN]) begin
         conv_running_q <= 1'b1;
      end else if (i_evt.conv_done) begin
         conv_running_q <= 1'b0;
      end
   end

   assign o_conv_start = i_wr && (i_addr == PST_IDX_CONV_CTRL)
                         && i_wdata[PST_B_CONV_RUN] && !conv_running_q;

   // conversion-done and low-supply flags: hardware set beats a clearing write
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         conv_done_flag_q  <= 1'b0;
         low_supply_flag_q <= 1'b0;
      end else begin
         if (i_evt.conv_done) begin
            conv_done_flag_q <= 1'b1;
         end else if (wr_evt && !i_wdata[PST_B_CONV_DONE]) begin
            conv_done_flag_q <= 1'b0;
         end
         if (supply_fell) begin
            low_supply_flag_q <= 1'b1;
         end else if (wr_evt && !i_wdata[PST_B_LOW_SUPPLY]) begin
            low_supply_flag_q <= 1'b0;
         end
      end
   end

   // wake enables, the only plain read/write bits of the status register
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wake_cfg_q <= PST_RST_ZERO;
      end else if (wr_evt) begin
         wake_cfg_q <= wr_merge(wake_cfg_q, i_wdata, PST_WM_EVT_STATUS);
      end
   end

   // timer and port-change event sets, in flag register bit order
   assign tmr_set = {i_evt.low_pulse_underflow, i_evt.high_pulse_underflow,
                     i_evt.timer_c_overflow, i_evt.timer_b_overflow,
                     i_evt.timer_a_overflow, 1'b0, port_changed,
                     i_evt.main_timer_overflow};

   // writing 0 clears, writing 1 keeps, a set in the same cycle wins
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tmr_flags_q <= PST_RST_ZERO;
      end else if (wr_tmr) begin
         tmr_flags_q <= ((tmr_flags_q & i_wdata) | tmr_set) & PST_WM_TMR_FLAGS;
      end else begin
         tmr_flags_q <= (tmr_flags_q | tmr_set) & PST_WM_TMR_FLAGS;
      end
   end

   // global enable follows the core; disabling wins over a same-cycle enable
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         global_en_q <= 1'b0;
      end else if (i_irq_cmd.irq_off_instr || i_irq_cmd.irq_taken) begin
         global_en_q <= 1'b0;
      end else if (i_irq_cmd.irq_on_instr || i_irq_cmd.irq_return_instr) begin
         global_en_q <= 1'b1;
      end
   end

   // plain configuration registers, reserved bits forced to zero
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         main_presc_q  <= PST_RST_PRE;
         port5_dir_q   <= PST_RST_DIR & PST_WM_PORT5_DIR;
         port6_dir_q   <= PST_RST_DIR & PST_WM_PORT6_DIR;
         port7_dir_q   <= PST_RST_DIR & PST_WM_PORT7_DIR;
         tmr_a_cfg_q   <= PST_RST_ZERO;
         tmr_bc_cfg_q  <= PST_RST_ZERO;
         carrier_cfg_q <= PST_RST_ZERO;
         second_mask_q <= PST_RST_ZERO;
         first_mask_q  <= PST_RST_ZERO;
      end else if (i_wr) begin
         unique case (i_addr)
            PST_IDX_MAIN_PRESC: begin
               main_presc_q <= wr_merge(main_presc_q, i_wdata, PST_WM_MAIN_PRESC);
            end
            PST_IDX_PORT5_DIR: begin
               port5_dir_q <= wr_merge(port5_dir_q, i_wdata, PST_WM_PORT5_DIR);
            end
            PST_IDX_PORT6_DIR: begin
               port6_dir_q <= wr_merge(port6_dir_q, i_wdata, PST_WM_PORT6_DIR);
            end
            PST_IDX_PORT7_DIR: begin
               port7_dir_q <= wr_merge(port7_dir_q, i_wdata, PST_WM_PORT7_DIR);
            end
            PST_IDX_TMR_A_CFG: begin
               tmr_a_cfg_q <= wr_merge(tmr_a_cfg_q, i_wdata, PST_WM_TMR_A_CFG);
            end
            PST_IDX_TMR_BC_CFG: begin
               tmr_bc_cfg_q <= wr_merge(tmr_bc_cfg_q, i_wdata, PST_WM_TMR_BC_CFG);
            end
            PST_IDX_CARRIER_CFG: begin
               carrier_cfg_q <= wr_merge(carrier_cfg_q, i_wdata, PST_WM_CARRIER_CFG);
            end
            PST_IDX_SECOND_MASK: begin
               second_mask_q <= wr_merge(second_mask_q, i_wdata, PST_WM_SECOND_MASK);
            end
            PST_IDX_FIRST_MASK: begin
               first_mask_q <= wr_merge(first_mask_q, i_wdata, PST_WM_FIRST_MASK);
            end
            default: begin
               // read-only, flag and unmapped indices handled elsewhere or ignored
            end
         endcase
      end
   end

   // raw status byte before masking; bit 7 high when the supply is fine
   assign evt_status_raw = {!supply_low_q, low_supply_flag_q, conv_done_flag_q, 1'b0,
                            wake_cfg_q[PST_B_CONV_WAKE], 1'b0,
                            wake_cfg_q[PST_B_PORT_WAKE], wake_cfg_q[PST_B_LOW_WAKE]};

   // read mux; unmapped indices answer zero
   always_comb begin
      rdata_d = 8'h00;
      unique case (i_addr)
         PST_IDX_CONV_UPPER:  rdata_d = conv_result_q[11:4];
         PST_IDX_CONV_NIBBLE: rdata_d = {4'h0, conv_result_q[11:8]};
         PST_IDX_CONV_LOW:    rdata_d = conv_result_q[7:0];
         PST_IDX_EVT_STATUS:  rdata_d = evt_status_raw & second_mask_q;
         PST_IDX_TMR_FLAGS:   rdata_d = tmr_flags_q & first_mask_q;
         PST_IDX_MAIN_PRESC: begin
            rdata_d = main_presc_q;
            rdata_d[PST_B_GLOBAL_EN] = global_en_q;
         end
         PST_IDX_PORT5_DIR:   rdata_d = port5_dir_q;
         PST_IDX_PORT6_DIR:   rdata_d = port6_dir_q;
         PST_IDX_PORT7_DIR:   rdata_d = port7_dir_q;
         PST_IDX_TMR_A_CFG:   rdata_d = tmr_a_cfg_q;
         PST_IDX_TMR_BC_CFG:  rdata_d = tmr_bc_cfg_q;
         PST_IDX_CARRIER_CFG: rdata_d = carrier_cfg_q;
         PST_IDX_SECOND_MASK: rdata_d = second_mask_q;
         PST_IDX_FIRST_MASK:  rdata_d = first_mask_q;
         PST_IDX_CONV_CTRL: begin
            rdata_d = 8'h00;
            rdata_d[PST_B_CONV_RUN] = conv_running_q;
         end
         default:             rdata_d = 8'h00;
      endcase
   end

   // read data stand for exactly the cycle after the strobe, zero otherwise
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= i_rd ? rdata_d : 8'h00;
      end
   end

   assign o_rdata = rdata_q;

   // main timer prescaler; a tick per ratio cycles, so overflow takes ratio times remaining counts
   assign main_term = ratio_term(main_presc_q[PST_B_MAIN_PS_EN], main_presc_q[2:0]);
   assign main_tick = (main_cnt_q >= main_term);

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         main_cnt_q <= 8'h00;
      end else if (main_tick) begin
         main_cnt_q <= 8'h00;
      end else begin
         main_cnt_q <= main_cnt_q + 8'h01;
      end
   end

   // timer c scaler; in carrier mode the modulator supplies the ticks instead
   assign c_up_mode = !(carrier_cfg_q[PST_B_MODULATOR] && carrier_cfg_q[PST_B_CARRIER_HF]);
   assign c_term    = ratio_term(carrier_cfg_q[PST_B_C_SCALE_EN], carrier_cfg_q[6:4]);
   assign c_tick    = c_up_mode ? (c_cnt_q >= c_term) : i_carrier_low_tick;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         c_cnt_q <= 8'h00;
      end else if (!c_up_mode || (c_cnt_q >= c_term)) begin
         c_cnt_q <= 8'h00;
      end else begin
         c_cnt_q <= c_cnt_q + 8'h01;
      end
   end

   // timer steering; the wide bit only matters while timer b runs
   assign o_tmr.timer_a_en      = tmr_a_cfg_q[PST_B_TMR_A_EN];
   assign o_tmr.timer_b_en      = tmr_bc_cfg_q[PST_B_TMR_B_EN];
   assign o_tmr.timer_b_wide_en = tmr_bc_cfg_q[PST_B_TMR_B_WIDE];
   assign o_tmr.timer_c_en      = tmr_bc_cfg_q[PST_B_TMR_C_EN];
   assign o_tmr.timer_c_up_mode = c_up_mode;
   assign o_tmr.main_tick       = main_tick;
   assign o_tmr.timer_c_tick    = c_tick;

   // interrupt request: flag and its mask bit, then the global enable
   assign o_irq_req = global_en_q && (|(tmr_flags_q & first_mask_q)
                      || (conv_done_flag_q && second_mask_q[PST_B_CONV_DONE]));

   // wake sources each need their enable bit
   assign o_wake = (conv_done_flag_q && wake_cfg_q[PST_B_CONV_WAKE])
                || (tmr_flags_q[PST_B_PORT_WAKE] && wake_cfg_q[PST_B_PORT_WAKE])
                || (low_supply_flag_q && wake_cfg_q[PST_B_LOW_WAKE]);

   // pins drive while their direction bit is zero; the infrared pin drives when modulating
   assign o_port5_oe = ~port5_dir_q & PST_WM_PORT5_DIR;
   assign o_port7_oe = ~port7_dir_q & PST_WM_PORT7_DIR;
   always_comb begin
      o_port6_oe = ~port6_dir_q & PST_WM_PORT6_DIR;
      o_port6_oe[PST_B_P6_IR_PIN] = o_port6_oe[PST_B_P6_IR_PIN]
                                    || carrier_cfg_q[PST_B_MODULATOR];
   end

   // modulator off pins the infrared level high
   assign o_infrared_out_pin = carrier_cfg_q[PST_B_MODULATOR] ? i_modulated_wave : 1'b1;
   assign o_infrared_pin_sel = carrier_cfg_q[PST_B_MODULATOR];

endmodule

`default_nettype wire

// ==== sim/pst_regs_monitor.sv ====
// port assertions of the register bank
`timescale 1ns/100ps
`default_nettype none
module pst_regs_chk
   import pst_pkg::*;
(
   input wire logic        i_clk,              // clock
   input wire logic        i_sys_rst,          // reset
   input wire logic [3:0]  i_addr,             // index
   input wire logic [7:0]  i_wdata,            // data
   input wire logic        i_wr,               // write
   input wire logic        i_rd,               // read
   input wire logic [7:0]  o_rdata,            // answer
   input wire logic        i_carrier_low_tick, // carrier tick
   input wire logic        i_modulated_wave,   // wave
   input wire pst_tmr_type o_tmr,              // steering
   input wire logic        o_conv_start,       // start
   input wire logic        o_infrared_out_pin, // ir level
   input wire logic        o_infrared_pin_sel  // ir select
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   a_rd_unmapped: assert property (i_rd && i_addr == 4'hf |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rd_nibble: assert property (i_rd && i_addr == 4'h1 |=> o_rdata[7:4] == 4'h0)
      else $error("nibble top bits set");
   a_rd_tmr_a: assert property (i_rd && i_addr == 4'h9 |=> (o_rdata & 8'hfb) == 8'h00)
      else $error("timer a fixed bits set");
   a_ir_idle: assert property (!o_infrared_pin_sel |-> o_infrared_out_pin)
      else $error("ir pin not high");
   a_ir_wave: assert property (o_infrared_pin_sel |-> o_infrared_out_pin == i_modulated_wave)
      else $error("ir pin not wave");
   a_c_carrier: assert property (!o_tmr.timer_c_up_mode |-> o_tmr.timer_c_tick == i_carrier_low_tick)
      else $error("carrier tick lost");
   a_conv_start: assert property (o_conv_start |-> i_wr && i_addr == 4'he && i_wdata[4])
      else $error("start without write");
   a_tick_one: assert property (i_wr && i_addr == 4'h5 && !i_wdata[3] |=> o_tmr.main_tick [*3])
      else $error("tick not 1:1");
   // main scenarios reached
   c_start: cover property (o_conv_start);
   c_ir: cover property (o_infrared_pin_sel && !o_tmr.timer_c_up_mode);
   c_tick: cover property (!o_tmr.main_tick);
endmodule
bind pst_regs pst_regs_chk chk_u (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
   .o_rdata, .i_carrier_low_tick, .i_modulated_wave, .o_tmr, .o_conv_start,
   .o_infrared_out_pin, .o_infrared_pin_sel);
`default_nettype wire

// ==== sim/pst_core_mdl.sv ====
// core model issuing register port accesses
`timescale 1ns/100ps
`default_nettype none
module pst_core_mdl (
   input  wire logic  i_clk,            // clock
   output logic [3:0] o_addr  = 4'h0,   // index
   output logic [7:0] o_wdata = 8'h00,  // data
   output logic       o_wr    = 1'b0,   // write
   output logic       o_rd    = 1'b0    // read
);
   // write; address and data with the write strobe held for one cycle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
   endtask
   // read, answer lands one cycle later
   task automatic rd(input logic [3:0] a);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench of the register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module tb;
   import pst_pkg::*;
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr, i_rd, rd_q = 1'b0, o_conv_start, o_irq_req;
   logic i_supply_low = 1'b0, i_carrier_low_tick = 1'b0, i_modulated_wave = 1'b0, o_wake;
   logic o_infrared_out_pin, o_infrared_pin_sel;
   logic [3:0] i_addr;
   logic [7:0] i_wdata, o_rdata, o_port5_oe, o_port6_oe, o_port7_oe, w, ex;
   logic [7:0] i_port5_pins = 8'h00;
   logic [11:0] i_conv_result = 12'h000;
   pst_evt_type i_evt = '0;
   pst_irq_cmd_type i_irq_cmd = '0;
   pst_tmr_type o_tmr;
   int error_cnt = 0, samples_checked = 0, n;
   logic [7:0] exp_q[$];
   pst_regs dut_u (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_evt,
      .i_conv_result, .i_irq_cmd, .i_supply_low, .i_port5_pins, .i_carrier_low_tick,
      .i_modulated_wave, .o_tmr, .o_conv_start, .o_irq_req, .o_wake, .o_port5_oe,
      .o_port6_oe, .o_port7_oe, .o_infrared_out_pin, .o_infrared_pin_sel);
   pst_core_mdl core_u (.i_clk, .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
   initial forever #25 i_clk = ~i_clk;
   // carrier ticks and wave wander at random
   always @(posedge i_clk) {i_carrier_low_tick, i_modulated_wave} <= 2'($urandom);
   // each answer against the oldest note
   always @(posedge i_clk) begin
      rd_q <= i_rd;
      if (rd_q) begin
         ex = exp_q.pop_front();
         `CHK(o_rdata, ex)
      end
   end
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      core_u.rd(a);
   endtask
   task automatic pulse(input logic [6:0] e, input logic [3:0] c);
      @(posedge i_clk) {i_evt, i_irq_cmd} <= {e, c};
      @(posedge i_clk) {i_evt, i_irq_cmd} <= 11'h000;
   endtask
   task automatic test_done;
      error_cnt += exp_q.size();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog at 8000 cycles, well beyond the under 2000 cycles of the run
   initial begin
      #400000;
      error_cnt++;
      test_done();
   end
   initial begin
      n = $urandom(32'hea4b);
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(4'h6, 8'h2f);
      rd(4'h7, 8'h80);
      rd(4'h8, 8'hff);
      `CHK({o_port5_oe, o_port6_oe, o_port7_oe}, 24'h000000)
      core_u.wr(4'h9, 8'hff);
      rd(4'h9, 8'h04);
      core_u.wr(4'ha, 8'hff);
      rd(4'ha, 8'hc4);
      `CHK(o_tmr[6:3], 4'hf)
      $display("config test done");
      i_conv_result <= 12'($urandom);
      core_u.wr(4'he, 8'h10);
      core_u.wr(4'he, 8'h00);
      rd(4'he, 8'h10);
      pulse(7'h01, 4'h0);
      rd(4'h0, i_conv_result[11:4]);
      rd(4'h1, {4'h0, i_conv_result[11:8]});
      rd(4'h2, i_conv_result[7:0]);
      rd(4'he, 8'h00);
      core_u.wr(4'hc, 8'hff);
      rd(4'h3, 8'ha0);
      core_u.wr(4'h3, 8'hff);
      rd(4'h3, 8'ha9);
      core_u.wr(4'h3, 8'h0b);
      rd(4'h3, 8'h89);
      i_supply_low <= 1'b1;
      repeat (8) @(posedge i_clk);
      rd(4'h3, 8'h09);
      `CHK(o_wake, 1'b1)
      $display("conversion test done");
      core_u.wr(4'hd, 8'hff);
      i_port5_pins <= 8'($urandom) | 8'h01;
      pulse(7'h7e, 4'h0);
      repeat (6) @(posedge i_clk);
      rd(4'h4, 8'hfb);
      // clear racing a main overflow: the set must win
      w = 8'($urandom) | 8'h01;
      fork
         core_u.wr(4'h4, w & 8'hfe);
         pulse(7'h02, 4'h0);
      join
      rd(4'h4, 8'hfb & w);
      for (int k = 0; k < 4; k++) begin
         pulse(7'h00, 4'h8 >> k);
         rd(4'h5, k[0] ? 8'h00 : 8'h40);
         `CHK(o_irq_req, !k[0])
      end
      $display("flag test done");
      for (int s = 0; s < 8; s++) begin
         core_u.wr(4'h5, 8'h08 | 8'(s));
         @(negedge i_clk);
         while (!o_tmr.main_tick) @(negedge i_clk);
         n = 0;
         do begin
            @(negedge i_clk);
            n++;
         end while (!o_tmr.main_tick && n < 600);
         `CHK(n, 2 << s)
      end
      core_u.wr(4'h5, 8'h00);
      $display("prescale test done");
      core_u.wr(4'hb, 8'h0c);
      rd(4'hb, 8'h0c);
      `CHK(o_infrared_pin_sel, 1'b1)
      `CHK(o_port6_oe, 8'h80)
      core_u.wr(4'hb, 8'h00);
      rd(4'hf, 8'h00);
      $display("carrier test done");
      repeat (2) @(posedge i_clk);
      test_done();
   end
endmodule
`default_nettype wire
